// >>> pmac_defines.vh
`ifndef PMAC_DEFINES_VH
`define PMAC_DEFINES_VH

// register byte addresses
`define PMAC_ADDR_RST_CTRL    12'h000
`define PMAC_ADDR_EVENTS      12'h004
`define PMAC_ADDR_MODE        12'h008
`define PMAC_ADDR_ENA         12'h00C
`define PMAC_ADDR_IFG         12'h010
`define PMAC_ADDR_HDX         12'h014
`define PMAC_ADDR_EVT_RAISE   12'h018

// reset control fields
`define PMAC_RST_MAC_RX       0
`define PMAC_RST_MAC_TX       1
`define PMAC_RST_PCS_RX       2
`define PMAC_RST_PCS_TX       3
`define PMAC_RST_USX_RX       4
`define PMAC_RST_USX_TX       5
`define PMAC_SPEED_LSB        8
`define PMAC_RST_CTRL_RESET   32'h0000003F

// speed select codes
`define PMAC_SPD_10           3'h0
`define PMAC_SPD_100          3'h1
`define PMAC_SPD_1000         3'h2
`define PMAC_SPD_NOCLK        3'h3
`define PMAC_SPD_USX2500      3'h6

// mode register
`define PMAC_MODE_FDX         0
`define PMAC_MODE_GIGA        4
`define PMAC_MODE_RESET       32'h00000001

// enable register
`define PMAC_ENA_RX           0
`define PMAC_ENA_TX           4

// gap register fields
`define PMAC_IFG_RX1_LSB      0
`define PMAC_IFG_RX2_LSB      8
`define PMAC_IFG_TX_LSB       16
`define PMAC_IFG_RESET        32'h000C0505

// half duplex register fields
`define PMAC_HDX_RETRY        0
`define PMAC_HDX_SEED_LOAD    1
`define PMAC_HDX_LATE_LSB     8
`define PMAC_HDX_SEED_LSB     16
`define PMAC_HDX_RESET        32'h00000000

// late collision base byte
`define PMAC_LATE_COL_BASE    8'h38

`endif

// >>> pmac_port_ctrl.v
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "pmac_defines.vh"

module pmac_port_ctrl #(
	parameter MAX_ATTEMPTS = 16
)(
	input  wire        REF_CLK,
	input  wire        RST_B,
	input  wire        CLK_EN,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	output reg  [31:0] PRDATA,
	input  wire [7:0]  EVENT_IN,
	input  wire        CRS_IN,
	input  wire        RX_FRAME_ACTIVE,
	input  wire        RX_DATA_VALID,
	input  wire        TX_FRAME_ACTIVE,
	input  wire        TX_COLLISION,
	input  wire [7:0]  TX_BYTE_COUNT,
	output wire [5:0]  PATH_RESET,
	output reg  [2:0]  SPEED_SEL,
	output reg         CLOCK_STOP,
	output reg         SPEED_VALID,
	output reg         FULL_DUPLEX,
	output reg         GIGA_MODE,
	output reg         RX_ACCEPT,
	output reg         RX_ABORT,
	output reg         TX_DEQUEUE_EN,
	output reg  [7:0]  TX_GAP_LEN,
	output reg         TX_GAP_DONE,
	output reg         TX_RETRANSMIT,
	output reg         TX_DROP,
	output reg  [15:0] BACKOFF_RAND,
	output reg         EVENT_IRQ
);

	// reset release, synchronised
	reg rst_meta_ff;
	reg rst_sync_ff;
	always @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire rst_n = rst_sync_ff;

	// event and carrier pins pass two flops before any logic looks at them
	reg [7:0] evt_meta_ff, evt_sync_ff;
	reg       crs_meta_ff, crs_sync_ff;
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_meta_ff <= 8'h00;
			evt_sync_ff <= 8'h00;
			crs_meta_ff <= 1'b0;
			crs_sync_ff <= 1'b0;
		end
		else if (CLK_EN)
		begin
			evt_meta_ff <= EVENT_IN;
			evt_sync_ff <= evt_meta_ff;
			crs_meta_ff <= CRS_IN;
			crs_sync_ff <= crs_meta_ff;
		end
	end

	// registers
	reg [5:0]  rst_bits_ff;
	reg [2:0]  speed_ff;
	reg [7:0]  events_ff;
	reg [7:0]  evt_prev_ff;
	reg        fdx_ff, giga_ff;
	reg        receive_path_enable_ff, transmit_path_enable_ff;
	reg [7:0]  ifg1_ff, ifg2_ff, txifg_ff;
	reg        retry_ff;
	reg [7:0]  late_ff;
	reg [15:0] seed_ff;
	reg        seed_load_ff;

	wire wr_en = PSEL & PENABLE & PWRITE & CLK_EN;
	wire rd_ok;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~rd_ok;
	assign PATH_RESET = rst_bits_ff;

	// address decode for the error answer; the read mux decodes on its own
	function addr_known;
		input [11:0] a;
		begin
			addr_known = (a == `PMAC_ADDR_RST_CTRL) | (a == `PMAC_ADDR_EVENTS) |
				(a == `PMAC_ADDR_MODE) | (a == `PMAC_ADDR_ENA) |
				(a == `PMAC_ADDR_IFG) | (a == `PMAC_ADDR_HDX) |
				(a == `PMAC_ADDR_EVT_RAISE);
		end
	endfunction
	assign rd_ok = addr_known(PADDR);

	// rising edge of each synchronised event
	wire [7:0] evt_rise = evt_sync_ff & ~evt_prev_ff;
	wire       evt_clr_wr = wr_en & (PADDR == `PMAC_ADDR_EVENTS);
	wire       evt_set_wr = wr_en & (PADDR == `PMAC_ADDR_EVT_RAISE);
	reg  [7:0] nxt_events;
	always @*
	begin
		nxt_events = events_ff;
		if (evt_clr_wr)
			nxt_events = nxt_events & ~PWDATA[7:0];
		// set wins over a simultaneous clear
		nxt_events = nxt_events | evt_rise;
		if (evt_set_wr)
			nxt_events = nxt_events | PWDATA[7:0];
	end

	// register writes
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_bits_ff  <= 6'h3F;
			speed_ff     <= `PMAC_SPD_10;
			events_ff    <= 8'h00;
			evt_prev_ff  <= 8'h00;
			fdx_ff       <= 1'b1;
			giga_ff      <= 1'b0;
			receive_path_enable_ff    <= 1'b0;
			transmit_path_enable_ff    <= 1'b0;
			ifg1_ff      <= 8'h05;
			ifg2_ff      <= 8'h05;
			txifg_ff     <= 8'h0C;
			retry_ff     <= 1'b0;
			late_ff      <= 8'h00;
			seed_ff      <= 16'h0000;
			seed_load_ff <= 1'b0;
		end
		else if (CLK_EN)
		begin
			evt_prev_ff  <= evt_sync_ff;
			events_ff    <= nxt_events;
			seed_load_ff <= 1'b0;
			if (wr_en)
			begin
				case (PADDR)
				`PMAC_ADDR_RST_CTRL:
				begin
					// all six set or cleared in one write
					rst_bits_ff <= PWDATA[5:0];
					speed_ff    <= PWDATA[`PMAC_SPEED_LSB +: 3];
				end
				`PMAC_ADDR_MODE:
				begin
					fdx_ff  <= PWDATA[`PMAC_MODE_FDX];
					// gigabit refused unless full duplex is written with it
					giga_ff <= PWDATA[`PMAC_MODE_GIGA] & PWDATA[`PMAC_MODE_FDX];
				end
				`PMAC_ADDR_ENA:
				begin
					receive_path_enable_ff <= PWDATA[`PMAC_ENA_RX];
					transmit_path_enable_ff <= PWDATA[`PMAC_ENA_TX];
				end
				`PMAC_ADDR_IFG:
				begin
					ifg1_ff  <= PWDATA[`PMAC_IFG_RX1_LSB +: 8];
					ifg2_ff  <= PWDATA[`PMAC_IFG_RX2_LSB +: 8];
					txifg_ff <= PWDATA[`PMAC_IFG_TX_LSB +: 8];
				end
				`PMAC_ADDR_HDX:
				begin
					retry_ff     <= PWDATA[`PMAC_HDX_RETRY];
					seed_load_ff <= PWDATA[`PMAC_HDX_SEED_LOAD];
					late_ff      <= PWDATA[`PMAC_HDX_LATE_LSB +: 8];
					seed_ff      <= PWDATA[`PMAC_HDX_SEED_LSB +: 16];
				end
				default:
				begin
					seed_load_ff <= 1'b0;
				end
				endcase
			end
		end
	end

	// read mux, registered data out
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			PRDATA <= 32'h00000000;
		else if (CLK_EN && PSEL && !PENABLE && !PWRITE)
		begin
			case (PADDR)
			`PMAC_ADDR_RST_CTRL: PRDATA <= {21'h00000, speed_ff, 2'h0, rst_bits_ff};
			`PMAC_ADDR_EVENTS:   PRDATA <= {24'h000000, events_ff};
			`PMAC_ADDR_MODE:     PRDATA <= {27'h000000, giga_ff, 3'h0, fdx_ff};
			`PMAC_ADDR_ENA:      PRDATA <= {27'h000000, transmit_path_enable_ff, 3'h0, receive_path_enable_ff};
			`PMAC_ADDR_IFG:      PRDATA <= {8'h00, txifg_ff, ifg2_ff, ifg1_ff};
			`PMAC_ADDR_HDX:      PRDATA <= {seed_ff, late_ff, 7'h00, retry_ff};
			default:             PRDATA <= 32'h00000000;
			endcase
		end
	end

	// speed and mode decode; half duplex legal only below gigabit
	wire hdx_active = ~fdx_ff & ~giga_ff & ((speed_ff == `PMAC_SPD_10) | (speed_ff == `PMAC_SPD_100));
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			SPEED_SEL   <= `PMAC_SPD_10;
			CLOCK_STOP  <= 1'b0;
			SPEED_VALID <= 1'b1;
			FULL_DUPLEX <= 1'b1;
			GIGA_MODE   <= 1'b0;
			TX_GAP_LEN  <= 8'h0C;
			EVENT_IRQ   <= 1'b0;
		end
		else if (CLK_EN)
		begin
			SPEED_SEL   <= speed_ff;
			CLOCK_STOP  <= (speed_ff == `PMAC_SPD_NOCLK);
			SPEED_VALID <= (speed_ff <= `PMAC_SPD_1000) | (speed_ff == `PMAC_SPD_USX2500);
			FULL_DUPLEX <= ~hdx_active;
			GIGA_MODE   <= giga_ff;
			TX_GAP_LEN  <= txifg_ff;
			EVENT_IRQ   <= |events_ff;
		end
	end

	// receive and transmit path gating
	reg tx_busy_ff;
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			RX_ACCEPT     <= 1'b0;
			RX_ABORT      <= 1'b0;
			TX_DEQUEUE_EN <= 1'b0;
			tx_busy_ff    <= 1'b0;
		end
		else if (CLK_EN)
		begin
			// receive off or held in reset drops the frame at once
			RX_ACCEPT <= receive_path_enable_ff & ~rst_bits_ff[`PMAC_RST_MAC_RX];
			RX_ABORT  <= RX_FRAME_ACTIVE & (~receive_path_enable_ff | rst_bits_ff[`PMAC_RST_MAC_RX] |
				(RX_DATA_VALID & ~RX_ACCEPT));
			tx_busy_ff <= TX_FRAME_ACTIVE;
			// only the next dequeue is held; a frame in flight completes
			TX_DEQUEUE_EN <= transmit_path_enable_ff & ~rst_bits_ff[`PMAC_RST_MAC_TX];
		end
	end

	// back-off randomizer: galois lfsr, seed loaded on request
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			BACKOFF_RAND <= 16'h0001;
		else if (CLK_EN)
		begin
			if (seed_load_ff)
				BACKOFF_RAND <= seed_ff;
			else if (BACKOFF_RAND == 16'h0000)
				BACKOFF_RAND <= 16'h0001; // never lock up at zero
			else
				BACKOFF_RAND <= {1'b0, BACKOFF_RAND[15:1]} ^ (BACKOFF_RAND[0] ? 16'hB400 : 16'h0000);
		end
	end

	// collision handling: border at byte 56 + field
	wire [8:0] late_border = {1'b0, `PMAC_LATE_COL_BASE} + {1'b0, late_ff};
	wire       early_col   = ({1'b0, TX_BYTE_COUNT} < late_border);
	reg  [4:0] attempts_ff;
	wire       excess      = (attempts_ff >= MAX_ATTEMPTS - 1);
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			TX_RETRANSMIT <= 1'b0;
			TX_DROP       <= 1'b0;
			attempts_ff   <= 5'h00;
		end
		else if (CLK_EN)
		begin
			TX_RETRANSMIT <= 1'b0;
			TX_DROP       <= 1'b0;
			if (!TX_FRAME_ACTIVE && tx_busy_ff && !TX_COLLISION)
				attempts_ff <= 5'h00;
			else if (TX_COLLISION && hdx_active)
			begin
				if (!early_col)
				begin
					TX_DROP     <= 1'b1;
					attempts_ff <= 5'h00;
				end
				else if (excess)
				begin
					// retry option restarts the back-off sequence
					TX_RETRANSMIT <= retry_ff;
					TX_DROP       <= ~retry_ff;
					attempts_ff   <= 5'h00;
				end
				else
				begin
					TX_RETRANSMIT <= 1'b1;
					attempts_ff   <= attempts_ff + 5'h01;
				end
			end
		end
	end

	// rx-to-tx gap timer, two parts
	localparam GAP_IDLE = 2'h0;
	localparam GAP_ONE  = 2'h1;
	localparam GAP_TWO  = 2'h2;
	localparam GAP_DONE = 2'h3;
	reg [1:0] gap_st_ff;
	reg [7:0] gap_cnt_ff;
	reg       crs_prev_ff;
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_st_ff   <= GAP_DONE;
			gap_cnt_ff  <= 8'h00;
			crs_prev_ff <= 1'b0;
			TX_GAP_DONE <= 1'b1;
		end
		else if (CLK_EN)
		begin
			crs_prev_ff <= crs_sync_ff;
			case (gap_st_ff)
			GAP_IDLE:
			begin
				TX_GAP_DONE <= 1'b0;
				if (!crs_sync_ff)
				begin
					gap_st_ff  <= GAP_ONE;
					gap_cnt_ff <= 8'h00;
				end
			end
			GAP_ONE:
			begin
				// noisy carrier restarts the first part
				if (crs_sync_ff != crs_prev_ff)
					gap_cnt_ff <= 8'h00;
				else if (gap_cnt_ff + 8'h01 >= ifg1_ff)
				begin
					gap_st_ff  <= GAP_TWO;
					gap_cnt_ff <= 8'h00;
				end
				else
					gap_cnt_ff <= gap_cnt_ff + 8'h01;
			end
			GAP_TWO:
			begin
				// carrier ignored here; gap always completes
				if (gap_cnt_ff + 8'h01 >= ifg2_ff)
				begin
					gap_st_ff   <= GAP_DONE;
					TX_GAP_DONE <= 1'b1;
				end
				else
					gap_cnt_ff <= gap_cnt_ff + 8'h01;
			end
			GAP_DONE:
			begin
				TX_GAP_DONE <= 1'b1;
				if (crs_sync_ff && hdx_active)
				begin
					gap_st_ff   <= GAP_IDLE;
					TX_GAP_DONE <= 1'b0;
				end
			end
			default:
				gap_st_ff <= GAP_DONE;
			endcase
		end
	end

endmodule

// >>> pmac_port_ctrl_sva.sv
`timescale 1ns/10ps
module pmac_port_ctrl_sva (
	input logic        REF_CLK,
	input logic        RST_B,
	input logic        PSEL,
	input logic        PENABLE,
	input logic        PWRITE,
	input logic [11:0] PADDR,
	input logic [5:0]  PATH_RESET,
	input logic [2:0]  SPEED_SEL,
	input logic        CLOCK_STOP,
	input logic        SPEED_VALID,
	input logic        FULL_DUPLEX,
	input logic        GIGA_MODE,
	input logic        RX_ACCEPT,
	input logic        TX_DEQUEUE_EN,
	input logic        TX_RETRANSMIT,
	input logic        TX_DROP,
	input logic        EVENT_IRQ
);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	// speed decode flags follow the code
	a_clock_stop: assert property (CLOCK_STOP == (SPEED_SEL == 3'h3)) else $error("stop flag");
	a_speed_ok: assert property (SPEED_VALID == (SPEED_SEL inside {3'h0, 3'h1, 3'h2, 3'h6}))
		else $error("valid");
	a_giga_fdx: assert property (GIGA_MODE |-> FULL_DUPLEX) else $error("giga in half");
	// a MAC rx or tx path held in reset must stay quiet
	a_rx_gate: assert property (PATH_RESET[0] && $past(PATH_RESET[0]) |-> !RX_ACCEPT) else $error("rx");
	a_tx_gate: assert property (PATH_RESET[1] && $past(PATH_RESET[1]) |-> !TX_DEQUEUE_EN) else $error("tx");
	a_col_one: assert property (!(TX_RETRANSMIT && TX_DROP)) else $error("both");
	// sticky request only falls after a clearing write two edges back
	a_irq_hold: assert property ($fell(EVENT_IRQ) |->
		$past(PSEL && PENABLE && PWRITE && PADDR == 12'h004, 2)) else $error("irq fell");
	a_power_rst: assert property ($rose(RST_B) |-> PATH_RESET == 6'h3F) else $error("power reset");
	c_retx: cover property (TX_RETRANSMIT);
	c_drop: cover property (TX_DROP);
	c_irq: cover property (EVENT_IRQ);
endmodule

bind pmac_port_ctrl pmac_port_ctrl_sva i_sva (.*);

// >>> pmac_phy_model.sv
`timescale 1ns/10ps
module pmac_phy_model (
	input  logic       clk,
	output logic [7:0] evt,
	output logic       crs,
	output logic       rx_act,
	output logic       tx_act,
	output logic       tx_col,
	output logic [7:0] tx_byte
);
	initial {evt, crs, rx_act, tx_act, tx_col, tx_byte} = '0;
	// event level held long enough to pass the sync stage
	task raise(input int i);
		@(posedge clk);
		evt[i] <= 1'b1;
		repeat (3) @(posedge clk);
		evt[i] <= 1'b0;
	endtask
	// carrier burst; noise is just a short burst
	task carrier(input int n);
		@(posedge clk);
		crs <= 1'b1;
		repeat (n) @(posedge clk);
		crs <= 1'b0;
	endtask
	task rx(input logic v);
		@(posedge clk);
		rx_act <= v;
	endtask
	// frame stays open so attempts add up
	task collide(input logic [7:0] b);
		@(posedge clk);
		tx_act <= 1'b1;
		tx_byte <= b;
		tx_col <= 1'b1;
		@(posedge clk);
		tx_col <= 1'b0;
		tx_byte <= ~b;
	endtask
endmodule

// >>> tb_port_mac_mode_reset_hdx.sv
`timescale 1ns/10ps
`include "pmac_defines.vh"
module tb_port_mac_mode_reset_hdx;
	logic        clk = 0, rst_b = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, sv;
	logic        pready, pslverr, se, crs, rx_act, tx_act, tx_col, cr, cd;
	logic [7:0]  evt, tx_byte, glen;
	logic [5:0]  prst;
	logic [2:0]  spd;
	logic        stop, spv, fdx, giga, rxa, rxab, txq, gdone, retx, drop, irq;
	logic [15:0] rnd;
	int          err_count = 0, num_checks = 0, n, ta, tb2;

	always #10 clk = ~clk;

	pmac_phy_model i_phy (.clk(clk), .evt(evt), .crs(crs), .rx_act(rx_act), .tx_act(tx_act),
		.tx_col(tx_col), .tx_byte(tx_byte));

	pmac_port_ctrl #(.MAX_ATTEMPTS(4)) i_dut (
		.REF_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
		.PRDATA(prdata), .EVENT_IN(evt), .CRS_IN(crs), .RX_FRAME_ACTIVE(rx_act),
		.RX_DATA_VALID(rx_act), .TX_FRAME_ACTIVE(tx_act), .TX_COLLISION(tx_col),
		.TX_BYTE_COUNT(tx_byte), .PATH_RESET(prst), .SPEED_SEL(spd), .CLOCK_STOP(stop),
		.SPEED_VALID(spv), .FULL_DUPLEX(fdx), .GIGA_MODE(giga), .RX_ACCEPT(rxa),
		.RX_ABORT(rxab), .TX_DEQUEUE_EN(txq), .TX_GAP_LEN(glen), .TX_GAP_DONE(gdone),
		.TX_RETRANSMIT(retx), .TX_DROP(drop), .BACKOFF_RAND(rnd), .EVENT_IRQ(irq));

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", s, e, g);
			err_count++;
		end
	endtask

	// one apb transfer; request held until pready seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_count++;
			complete_run;
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
		repeat (2) @(posedge clk);
	endtask

	task rc(input string s, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask

	// count edges until the gap ends, at most 200
	task gap(output int t);
		t = 0;
		while (gdone !== 1'b1 && t < 200)
		begin
			@(posedge clk);
			t++;
		end
		// a gap that never ends is a failure, not a hang
		if (gdone !== 1'b1)
		begin
			err_count++;
			complete_run;
		end
	endtask

	// one collision; the answer is a single pulse soon after
	task col(input logic [7:0] b, input logic [1:0] e);
		cr = 0;
		cd = 0;
		i_phy.collide(b);
		repeat (3)
		begin
			@(posedge clk);
			cr |= retx;
			cd |= drop;
		end
		chk("collision", 32'(e), {30'h0, cr, cd});
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		// power-up state
		chk("reset bits", 32'h3F, 32'(prst));
		rc("rst reg", 12'h000, `PMAC_RST_CTRL_RESET);
		rc("mode reg", 12'h008, `PMAC_MODE_RESET);
		rc("gap reg", 12'h010, `PMAC_IFG_RESET);
		rc("unmapped", 12'h01C, 32'h0);
		chk("slverr", 32'h1, 32'(se));
		wr(12'h000, 32'h200);
		chk("all clear", 32'h0, 32'(prst));
		// each reset on its own
		for (int i = 0; i < 6; i++)
		begin
			wr(12'h000, 32'h200 | (32'h1 << i));
			chk("one reset", 32'h1 << i, 32'(prst));
		end
		wr(12'h000, 32'h23F);
		wr(12'h000, 32'h200);
		chk("cycle", 32'h200, {21'h0, spd, 2'h0, prst});
		// every speed code
		for (int c = 0; c < 8; c++)
		begin
			wr(12'h000, 32'(c) << 8);
			chk("stop", 32'(c == 3), 32'(stop));
			chk("valid", 32'(c < 3 || c == 6), 32'(spv));
		end
		// duplex and gigabit
		wr(12'h008, 32'h0);
		wr(12'h000, 32'h600);
		chk("usx fdx", 32'h1, 32'(fdx));
		wr(12'h000, 32'h200);
		chk("1000 fdx", 32'h1, 32'(fdx));
		wr(12'h000, 32'h0);
		chk("half", 32'h0, 32'(fdx));
		wr(12'h008, 32'h10);
		rc("giga refused", 12'h008, 32'h0);
		wr(12'h008, 32'h11);
		chk("giga", 32'h3, {30'h0, giga, fdx});
		// path enables, resets and abort
		wr(12'h00C, 32'h11);
		chk("enabled", 32'h3, {30'h0, rxa, txq});
		wr(12'h000, 32'h1);
		chk("rx reset", 32'h0, 32'(rxa));
		wr(12'h000, 32'h0);
		i_phy.rx(1'b1);
		wr(12'h00C, 32'h10);
		chk("abort", 32'h2, {30'h0, rxab, rxa});
		i_phy.rx(1'b0);
		wr(12'h00C, 32'h0);
		chk("tx off", 32'h0, 32'(txq));
		wr(12'h00C, 32'h11);
		// clock enable low: writes lost, state frozen
		clk_en <= 1'b0;
		@(posedge clk);
		sv = 32'(rnd);
		wr(12'h00C, 32'h0);
		chk("frozen rand", sv, 32'(rnd));
		clk_en <= 1'b1;
		rc("frozen", 12'h00C, 32'h11);
		// rx-to-tx gap in half duplex
		wr(12'h008, 32'h0);
		wr(12'h010, 32'h00160A03);
		chk("tx gap len", 32'h16, 32'(glen));
		i_phy.carrier(4);
		gap(ta);
		i_phy.carrier(4);
		i_phy.carrier(1);
		gap(tb2);
		chk("part one", 32'(ta), 32'(tb2));
		i_phy.carrier(4);
		repeat (6) @(posedge clk);
		i_phy.carrier(1);
		gap(tb2);
		chk("part two", 32'(ta), 32'(tb2 + 8));
		wr(12'h010, 32'h000C1403);
		i_phy.carrier(4);
		gap(tb2);
		chk("gap sum", 32'd10, 32'(tb2 - ta));
		// collisions and the late border
		for (int k = 0; k < 4; k++)
			col(8'h0A, k == 3 ? 2'b01 : 2'b10);
		col(8'h37, 2'b10);
		col(8'h38, 2'b01);
		wr(12'h014, 32'h200);
		col(8'h39, 2'b10);
		col(8'h3A, 2'b01);
		wr(12'h014, 32'h1);
		for (int k = 0; k < 5; k++)
			col(8'h0A, 2'b10);
		// same seed gives same sequence
		wr(12'h014, 32'h12340002);
		sv = 32'(rnd);
		chk("seed value", 32'h1234, sv);
		wr(12'h014, 32'h12340002);
		chk("seed", sv, 32'(rnd));
		rc("seed load", 12'h014, 32'h12340000);
		// sticky events and their request
		for (int i = 0; i < 8; i++)
		begin
			i_phy.raise(i);
			repeat (4) @(posedge clk);
			rc("events", 12'h004, (32'h2 << i) - 1);
			chk("irq", 32'h1, 32'(irq));
		end
		wr(12'h004, 32'hFF);
		rc("cleared", 12'h004, 32'h0);
		chk("irq off", 32'h0, 32'(irq));
		// reset again in mid-run
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("rerun", 32'h3F, 32'(prst));
		complete_run;
	end
endmodule
